// >>> cli_cycle_counter.sv
// cycle counter giving a one-cycle tick every limit cycles while running.
// assumes run_i from logic on the same clock; dropping run_i restarts it.
`timescale 1ns/1ps
`default_nettype none
module cli_cycle_counter
  import cli_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] limit_i,
  output var  logic         tick_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;

  // count up, wrap at the limit; idle counter holds zero
  always_comb begin
    cnt_d  = '0;
    tick_d = 1'b0;
    if (run_i) begin
      if (cnt_q == limit_i - W'(1)) begin
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule // cli_cycle_counter
`default_nettype wire

// >>> cli_detector.sv
// cold-load and magnetising-inrush detector with its register slave.
// assumes magnitudes, ratios and the harmonic valid strobe come from
// logic on CORE_CLK_I, so none of them is resynchronised.
//
// Notes on behaviour
// - cold load when all phases idle, then one exceeds start within 80 ms
// - cold load holds until max time ends or current drops below pickup
// - cold load and inrush both drive output matrix and blocking matrix
// - inrush needs cold-load start plus a phase ratio above harmonic setting
// - harmonic setting zero makes inrush follow cold load exactly
// - inrush blocking starts at the current rise, before any harmonic result
// - first harmonic result after activation keeps or releases inrush blocking
// - no detection unless all phases were below idle before the rise
// - no detection if current lingers between idle and start over 80 ms
// - idle threshold settable 0.01 to 0.50 times nominal
// - start threshold settable 0.30 to 10.00 times nominal
// - maximum time settable up to 300.00 s in 0.01 s steps
// - harmonic start setting integer percent 0 to 99
`timescale 1ns/1ps
`default_nettype none
module cli_detector
  import cli_pkg::*;
#(
  parameter int unsigned WIN_CYCLES_P  = WIN_CYCLES,
  parameter int unsigned STEP_CYCLES_P = STEP_CYCLES
) (
  input  wire logic               CORE_CLK_I,
  input  wire logic               RST_B_I,
  input  wire logic [MAG_W-1:0]   PH1_MAG_I,
  input  wire logic [MAG_W-1:0]   PH2_MAG_I,
  input  wire logic [MAG_W-1:0]   PH3_MAG_I,
  input  wire logic [RATIO_W-1:0] PH1_SECOND_HARMONIC_RATIO_I,
  input  wire logic [RATIO_W-1:0] PH2_SECOND_HARMONIC_RATIO_I,
  input  wire logic [RATIO_W-1:0] PH3_SECOND_HARMONIC_RATIO_I,
  input  wire logic               HARM_VALID_I,
  input  wire logic [ADDR_W-1:0]  ADDR_I,
  input  wire logic [DATA_W-1:0]  WDATA_I,
  input  wire logic               WR_STB_I,
  input  wire logic               RD_STB_I,
  output var  logic [DATA_W-1:0]  RDATA_O,
  output var  logic               COLD_LOAD_O,
  output var  logic               INRUSH_O,
  output var  logic               OMX_COLD_O,
  output var  logic               OMX_INRUSH_O,
  output var  logic               BMX_COLD_O,
  output var  logic               BMX_INRUSH_O,
  output var  logic               IRQ_O
);

  logic [MAG_W-1:0]   mag   [NPH];
  logic [RATIO_W-1:0] ratio [NPH];
  logic [NPH-1:0]     below_idle;
  logic [NPH-1:0]     above_start;
  logic [NPH-1:0]     below_start;
  logic [NPH-1:0]     above_harm;
  logic               all_below_idle;
  logic               any_above_start;
  logic               all_below_start;
  logic               any_above_harm;

  logic [MAG_W-1:0]   idle_set_q,  idle_set_d;
  logic [MAG_W-1:0]   start_set_q, start_set_d;
  logic [MAXT_W-1:0]  max_set_q,   max_set_d;
  logic [RATIO_W-1:0] harm_set_q,  harm_set_d;
  logic [ROUTE_W-1:0] route_q,     route_d;
  logic [EV_W-1:0]    mask_q,      mask_d;
  logic [EV_W-1:0]    ev_q,        ev_d;
  logic [EV_W-1:0]    ev_set;
  logic [DATA_W-1:0]  rdata_q,     rdata_d;
  logic               irq_q,       irq_d;

  cli_state_e         state_q,     state_d;
  logic [MAXT_W-1:0]  step_cnt_q,  step_cnt_d;
  logic               decided_q,   decided_d;
  logic               released_q,  released_d;
  logic               cold_q,      cold_d;
  logic               inrush_q,    inrush_d;
  logic [ROUTE_W-1:0] mtx_q,       mtx_d;
  logic               win_tick;
  logic               step_tick;
  logic               max_expire;

  assign mag[0]   = PH1_MAG_I;
  assign mag[1]   = PH2_MAG_I;
  assign mag[2]   = PH3_MAG_I;
  assign ratio[0] = PH1_SECOND_HARMONIC_RATIO_I;
  assign ratio[1] = PH2_SECOND_HARMONIC_RATIO_I;
  assign ratio[2] = PH3_SECOND_HARMONIC_RATIO_I;

  // per-phase threshold comparisons
  genvar p;
  generate
    for (p = 0; p < NPH; p++) begin : g_phase
      assign below_idle[p]  = mag[p] < idle_set_q;
      assign above_start[p] = mag[p] > start_set_q;
      assign below_start[p] = mag[p] < start_set_q;
      assign above_harm[p]  = ratio[p] > harm_set_q;
    end
  endgenerate

  assign all_below_idle  = &below_idle;
  assign any_above_start = |above_start;
  assign all_below_start = &below_start;
  assign any_above_harm  = |above_harm;

  // 80 ms window from leaving idle, and the 10 ms step of the max timer
  cli_cycle_counter #(.W(CNT_W)) u_win_cnt (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .run_i   (state_q == ST_RISING),
    .limit_i (CNT_W'(WIN_CYCLES_P)),
    .tick_o  (win_tick)
  );

  cli_cycle_counter #(.W(CNT_W)) u_step_cnt (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .run_i   (state_q == ST_ACTIVE),
    .limit_i (CNT_W'(STEP_CYCLES_P)),
    .tick_o  (step_tick)
  );

  // max time ends at the tick that completes the set number of steps
  assign max_expire = (state_q == ST_ACTIVE) && step_tick
                      && (step_cnt_q >= max_set_q - MAXT_W'(1));

  // detection sequence, harmonic decision and output terms
  always_comb begin
    state_d    = state_q;
    step_cnt_d = '0;
    decided_d  = 1'b0;
    released_d = 1'b0;
    case (state_q)
      ST_UNARMED: begin
        if (all_below_idle) state_d = ST_ARMED;
      end
      ST_ARMED: begin
        if (any_above_start) state_d = ST_ACTIVE;
        else if (!all_below_idle) state_d = ST_RISING;
      end
      ST_RISING: begin
        if (any_above_start) state_d = ST_ACTIVE;
        else if (all_below_idle) state_d = ST_ARMED;
        else if (win_tick) state_d = ST_LOCKOUT;
      end
      ST_ACTIVE: begin
        step_cnt_d = step_tick ? step_cnt_q + MAXT_W'(1) : step_cnt_q;
        decided_d  = decided_q;
        released_d = released_q;
        if (!decided_q && HARM_VALID_I) begin
          decided_d  = 1'b1;
          released_d = !any_above_harm;
        end
        if (all_below_start || max_expire) state_d = ST_UNARMED;
      end
      ST_LOCKOUT: begin
        if (all_below_idle) state_d = ST_ARMED;
      end
      default: state_d = ST_UNARMED;
    endcase
    cold_d = (state_d == ST_ACTIVE);
    // inrush on from the rise itself; zero setting never releases it
    inrush_d = cold_d && (!released_d || harm_set_q == HARM_MIN);
    mtx_d[RT_OMX_COLD] = cold_d && route_q[RT_OMX_COLD];
    mtx_d[RT_OMX_INR]  = inrush_d && route_q[RT_OMX_INR];
    mtx_d[RT_BMX_COLD] = cold_d && route_q[RT_BMX_COLD];
    mtx_d[RT_BMX_INR]  = inrush_d && route_q[RT_BMX_INR];
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      state_q    <= ST_UNARMED;
      step_cnt_q <= '0;
      decided_q  <= 1'b0;
      released_q <= 1'b0;
      cold_q     <= 1'b0;
      inrush_q   <= 1'b0;
      mtx_q      <= '0;
    end else begin
      state_q    <= state_d;
      step_cnt_q <= step_cnt_d;
      decided_q  <= decided_d;
      released_q <= released_d;
      cold_q     <= cold_d;
      inrush_q   <= inrush_d;
      mtx_q      <= mtx_d;
    end
  end

  // register slave: writes clamp settings into range, reads answer next cycle
  always_comb begin
    idle_set_d  = idle_set_q;
    start_set_d = start_set_q;
    max_set_d   = max_set_q;
    harm_set_d  = harm_set_q;
    route_d     = route_q;
    mask_d      = mask_q;
    rdata_d     = '0;
    if (WR_STB_I) begin
      case (ADDR_I)
        ADDR_IDLE: begin
          if (WDATA_I < DATA_W'(IDLE_MIN)) idle_set_d = IDLE_MIN;
          else if (WDATA_I > DATA_W'(IDLE_MAX)) idle_set_d = IDLE_MAX;
          else idle_set_d = WDATA_I[MAG_W-1:0];
        end
        ADDR_START: begin
          if (WDATA_I < DATA_W'(START_MIN)) start_set_d = START_MIN;
          else if (WDATA_I > DATA_W'(START_MAX)) start_set_d = START_MAX;
          else start_set_d = WDATA_I[MAG_W-1:0];
        end
        ADDR_MAXT: begin
          if (WDATA_I < DATA_W'(MAXT_MIN)) max_set_d = MAXT_MIN;
          else if (WDATA_I > DATA_W'(MAXT_MAX)) max_set_d = MAXT_MAX;
          else max_set_d = WDATA_I[MAXT_W-1:0];
        end
        ADDR_HARM: begin
          if (WDATA_I > DATA_W'(HARM_MAX)) harm_set_d = HARM_MAX;
          else harm_set_d = WDATA_I[RATIO_W-1:0];
        end
        ADDR_ROUTE: route_d = WDATA_I[ROUTE_W-1:0];
        ADDR_MASK:  mask_d  = WDATA_I[EV_W-1:0];
        default: ;
      endcase
    end
    if (RD_STB_I) begin
      case (ADDR_I)
        ADDR_IDLE:   rdata_d = DATA_W'(idle_set_q);
        ADDR_START:  rdata_d = DATA_W'(start_set_q);
        ADDR_MAXT:   rdata_d = DATA_W'(max_set_q);
        ADDR_HARM:   rdata_d = DATA_W'(harm_set_q);
        ADDR_ROUTE:  rdata_d = DATA_W'(route_q);
        ADDR_EVENT:  rdata_d = DATA_W'(ev_q);
        ADDR_MASK:   rdata_d = DATA_W'(mask_q);
        ADDR_STATUS: begin
          rdata_d[STS_COLD]            = cold_q;
          rdata_d[STS_INRUSH]          = inrush_q;
          rdata_d[STS_RELEASED]        = released_q;
          rdata_d[STS_DECIDED]         = decided_q;
          rdata_d[STS_STATE+2:STS_STATE] = state_q;
        end
        default: rdata_d = '0;   // unmapped reads return zero
      endcase
    end
  end

  // sticky events: a new event in the read cycle survives the read-clear
  always_comb begin
    ev_set = '0;
    ev_set[EV_COLD_START]   = cold_d && !cold_q;
    ev_set[EV_INRUSH_START] = inrush_d && !inrush_q;
    ev_set[EV_COLD_END]     = !cold_d && cold_q;
    ev_set[EV_REJECT]       = (state_d == ST_LOCKOUT) && (state_q != ST_LOCKOUT);
    ev_d = ev_q;
    if (RD_STB_I && ADDR_I == ADDR_EVENT) ev_d = '0;
    ev_d  = ev_d | ev_set;
    irq_d = |(ev_d & mask_d);
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      idle_set_q  <= IDLE_RST;
      start_set_q <= START_RST;
      max_set_q   <= MAXT_RST;
      harm_set_q  <= HARM_RST;
      route_q     <= ROUTE_RST;
      mask_q      <= MASK_RST;
      ev_q        <= '0;
      rdata_q     <= '0;
      irq_q       <= 1'b0;
    end else begin
      idle_set_q  <= idle_set_d;
      start_set_q <= start_set_d;
      max_set_q   <= max_set_d;
      harm_set_q  <= harm_set_d;
      route_q     <= route_d;
      mask_q      <= mask_d;
      ev_q        <= ev_d;
      rdata_q     <= rdata_d;
      irq_q       <= irq_d;
    end
  end

  assign RDATA_O      = rdata_q;
  assign COLD_LOAD_O  = cold_q;
  assign INRUSH_O     = inrush_q;
  assign OMX_COLD_O   = mtx_q[RT_OMX_COLD];
  assign OMX_INRUSH_O = mtx_q[RT_OMX_INR];
  assign BMX_COLD_O   = mtx_q[RT_BMX_COLD];
  assign BMX_INRUSH_O = mtx_q[RT_BMX_INR];
  assign IRQ_O        = irq_q;

  // checks on the detection sequence
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_first_result;
    cold_q && !decided_q && HARM_VALID_I && !any_above_harm && harm_set_q != HARM_MIN;
  endsequence

  sequence s_lingering;
    state_q == ST_RISING && win_tick && !any_above_start && !all_below_idle;
  endsequence

  chk_cold_needs_arm: assert property ($rose(cold_q) |->
    $past(state_q) inside {ST_ARMED, ST_RISING})
    else $error("cold load raised without an armed idle history");
  chk_window_lockout: assert property (s_lingering |=>
    state_q == ST_LOCKOUT ##1 !cold_q)
    else $error("lingering rise not locked out");
  chk_max_time_end: assert property ((cold_q && step_tick
    && step_cnt_q == max_set_q - MAXT_W'(1)) |=> !cold_q)
    else $error("cold load outlived maximum time");
  chk_pickup_end: assert property ((cold_q && all_below_start)
    |=> !cold_q && !inrush_q)
    else $error("cold load held below pickup");
  chk_inrush_in_cold: assert property (inrush_q |-> cold_q)
    else $error("inrush without cold load");
  chk_inrush_at_rise: assert property ($rose(cold_q) |->
    inrush_q && $rose(inrush_q))
    else $error("inrush not raised at the rise");
  chk_zero_harm: assert property ((harm_set_q == HARM_MIN)
    |=> inrush_q == cold_q)
    else $error("inrush differs from cold load at zero setting");
  chk_release_decision: assert property (s_first_result |=>
    !inrush_q ##1 !inrush_q)
    else $error("inrush kept without harmonic content");
  chk_rearm_idle: assert property ((state_q == ST_ARMED)
    && $past(state_q) != ST_ARMED && $past(state_q) != ST_RISING |-> $past(all_below_idle))
    else $error("re-armed without all phases idle");
  chk_route_both: assert property ((cold_q && route_q == ROUTE_RST
    && $stable(route_q)) |-> OMX_COLD_O && BMX_COLD_O)
    else $error("cold load missing from a matrix");
  chk_setting_range: assert property ((idle_set_q >= IDLE_MIN)
    && idle_set_q <= IDLE_MAX && start_set_q <= START_MAX && max_set_q >= MAXT_MIN
    && start_set_q >= START_MIN && max_set_q <= MAXT_MAX && harm_set_q <= HARM_MAX)
    else $error("setting out of range");

endmodule // cli_detector
`default_nettype wire

// >>> cli_meas_model.sv
// measurement chain model: phase magnitudes, ratios and harmonic strobe.
// assumes requests from the bench on the same clock as the detector.
`timescale 1ns/1ps
`default_nettype none
module cli_meas_model
  import cli_pkg::*;
#(
  parameter int CYC_P = 8
) (
  input  wire logic               clk_i,
  input  wire logic [MAG_W-1:0]   mag_req_i,
  input  wire logic [1:0]         ph_sel_i,
  input  wire logic [RATIO_W-1:0] ratio_req_i,
  output var  logic [MAG_W-1:0]   ph1_o,
  output var  logic [MAG_W-1:0]   ph2_o,
  output var  logic [MAG_W-1:0]   ph3_o,
  output var  logic [RATIO_W-1:0] r1_o,
  output var  logic [RATIO_W-1:0] r2_o,
  output var  logic [RATIO_W-1:0] r3_o,
  output var  logic               hv_o
);
  int cnt = 0;
  // selected phase carries the request, the rest sit at zero; sel 0 = all magnitudes, no ratios
  always @(posedge clk_i) begin
    ph1_o <= (ph_sel_i inside {2'd0, 2'd1}) ? mag_req_i : '0;
    ph2_o <= (ph_sel_i inside {2'd0, 2'd2}) ? mag_req_i : '0;
    ph3_o <= (ph_sel_i inside {2'd0, 2'd3}) ? mag_req_i : '0;
    r1_o  <= (ph_sel_i == 2'd1) ? ratio_req_i : '0;
    r2_o  <= (ph_sel_i == 2'd2) ? ratio_req_i : '0;
    r3_o  <= (ph_sel_i == 2'd3) ? ratio_req_i : '0;
    // free-running full-cycle result strobe, never in step with the bench
    cnt   <= (cnt == CYC_P - 1) ? 0 : cnt + 1;
    hv_o  <= (cnt == CYC_P - 1);
  end
endmodule // cli_meas_model
`default_nettype wire

// >>> cli_pkg.sv
// package for the cold-load and inrush detector: widths, register map,
// setting limits, reset values, timing counts and the state encoding.
// assumes a 10 MHz core clock; magnitudes in steps of 0.01 x nominal current.
package cli_pkg;

  // clock rate and the time figures, counts derived from them
  localparam int unsigned CLK_FREQ_KHZ = 10000;
  localparam int unsigned WIN_TIME_MS  = 80;
  localparam int unsigned WIN_CYCLES   = WIN_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned STEP_TIME_MS = 10;
  localparam int unsigned STEP_CYCLES  = STEP_TIME_MS * CLK_FREQ_KHZ;

  // widths
  localparam int NPH     = 3;
  localparam int CNT_W   = 20;
  localparam int MAG_W   = 16;
  localparam int RATIO_W = 7;
  localparam int MAXT_W  = 15;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int EV_W    = 4;
  localparam int ROUTE_W = 4;

  // setting limits (idle and start in 0.01 x In, max time in 10 ms, ratio in %)
  localparam logic [MAG_W-1:0]   IDLE_MIN  = 16'h0001;
  localparam logic [MAG_W-1:0]   IDLE_MAX  = 16'h0032;
  localparam logic [MAG_W-1:0]   START_MIN = 16'h001E;
  localparam logic [MAG_W-1:0]   START_MAX = 16'h03E8;
  localparam logic [MAXT_W-1:0]  MAXT_MIN  = 15'h0001;
  localparam logic [MAXT_W-1:0]  MAXT_MAX  = 15'h7530;
  localparam logic [RATIO_W-1:0] HARM_MIN  = 7'h00;
  localparam logic [RATIO_W-1:0] HARM_MAX  = 7'h63;

  // reset values
  localparam logic [MAG_W-1:0]   IDLE_RST  = 16'h000A;
  localparam logic [MAG_W-1:0]   START_RST = 16'h0064;
  localparam logic [MAXT_W-1:0]  MAXT_RST  = 15'h01F4;
  localparam logic [RATIO_W-1:0] HARM_RST  = 7'h14;
  localparam logic [ROUTE_W-1:0] ROUTE_RST = 4'hF;
  localparam logic [EV_W-1:0]    MASK_RST  = 4'h0;

  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_IDLE   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_START  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_MAXT   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_HARM   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_ROUTE  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_EVENT  = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 8'h1C;

  // event bits
  localparam int EV_COLD_START   = 0;
  localparam int EV_INRUSH_START = 1;
  localparam int EV_COLD_END     = 2;
  localparam int EV_REJECT       = 3;

  // route bits: output matrix and blocking matrix
  localparam int RT_OMX_COLD = 0;
  localparam int RT_OMX_INR  = 1;
  localparam int RT_BMX_COLD = 2;
  localparam int RT_BMX_INR  = 3;

  // status fields
  localparam int STS_COLD     = 0;
  localparam int STS_INRUSH   = 1;
  localparam int STS_RELEASED = 2;
  localparam int STS_DECIDED  = 3;
  localparam int STS_STATE    = 4;

  typedef enum logic [2:0] {
    ST_UNARMED = 3'b000,
    ST_ARMED   = 3'b001,
    ST_RISING  = 3'b010,
    ST_ACTIVE  = 3'b011,
    ST_LOCKOUT = 3'b100
  } cli_state_e;

endpackage

// >>> tb_top.sv
// self-checking bench for the cold-load and inrush detector.
// assumes cli_meas_model stands in for the measurement chain.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cli_pkg::*;
;
  localparam int CYC = 8;
  localparam int WIN = 20;
  localparam logic [MAG_W-1:0] HI = 16'h00C8;
  localparam logic [MAG_W-1:0] MID = 16'h0032;
  localparam logic [MAG_W-1:0] LO = 16'h0000;
  logic               clk, rst_b, wr_stb, rd_stb, hv;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wdata, rdata, rd_val;
  logic [MAG_W-1:0]   mag_req, ph1, ph2, ph3;
  logic [1:0]         ph_sel;
  logic [RATIO_W-1:0] ratio_req, r1, r2, r3;
  logic               cold, inr, omc, omi, bmc, bmi, irq;
  int                 n_mismatch, comparisons;

  cli_meas_model #(.CYC_P(CYC)) u_meas (.clk_i(clk), .mag_req_i(mag_req),
    .ph_sel_i(ph_sel), .ratio_req_i(ratio_req), .ph1_o(ph1), .ph2_o(ph2),
    .ph3_o(ph3), .r1_o(r1), .r2_o(r2), .r3_o(r3), .hv_o(hv));
  // small window and step so the run stays short
  cli_detector #(.WIN_CYCLES_P(WIN), .STEP_CYCLES_P(5)) u_dut (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .PH1_MAG_I(ph1), .PH2_MAG_I(ph2),
    .PH3_MAG_I(ph3), .PH1_SECOND_HARMONIC_RATIO_I(r1),
    .PH2_SECOND_HARMONIC_RATIO_I(r2), .PH3_SECOND_HARMONIC_RATIO_I(r3),
    .HARM_VALID_I(hv), .ADDR_I(addr), .WDATA_I(wdata), .WR_STB_I(wr_stb),
    .RD_STB_I(rd_stb), .RDATA_O(rdata), .COLD_LOAD_O(cold), .INRUSH_O(inr),
    .OMX_COLD_O(omc), .OMX_INRUSH_O(omi), .BMX_COLD_O(bmc),
    .BMX_INRUSH_O(bmi), .IRQ_O(irq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // waits end just after the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    rd_val = rdata;
  endtask
  task automatic set_mag(input logic [MAG_W-1:0] m, input logic [1:0] p,
                         input logic [RATIO_W-1:0] r);
    @(posedge clk);
    mag_req <= m;
    ph_sel <= p;
    ratio_req <= r;
  endtask
  task automatic wait_cold(input int mx);
    int i;
    i = 0;
    while (cold !== 1'b1 && i < mx) begin
      cyc(1);
      i++;
    end
  endtask

  task automatic t_regs();
    logic [ADDR_W-1:0] a [7];
    logic [DATA_W-1:0] e [7];
    a = '{ADDR_IDLE, ADDR_START, ADDR_MAXT, ADDR_HARM, ADDR_ROUTE, ADDR_MASK, 8'h20};
    e = '{32'(IDLE_RST), 32'(START_RST), 32'(MAXT_RST), 32'(HARM_RST),
          32'(ROUTE_RST), 32'(MASK_RST), 32'h0};
    chkb(cold, 1'b0);
    chkb(irq, 1'b0);
    for (int i = 0; i < 7; i++) begin
      rd(a[i]);
      chk(rd_val, e[i]);
    end
    $display("test regs done");
  endtask

  // out-of-range settings land on the nearest limit
  task automatic t_clamp();
    logic [ADDR_W-1:0] a [7];
    logic [DATA_W-1:0] w [7];
    logic [DATA_W-1:0] e [7];
    a = '{ADDR_IDLE, ADDR_IDLE, ADDR_START, ADDR_START, ADDR_MAXT, ADDR_MAXT, ADDR_HARM};
    w = '{32'h0, 32'hFFFF, 32'h0, 32'hFFFF, 32'h0, 32'h7FFF, 32'h7F};
    e = '{32'(IDLE_MIN), 32'(IDLE_MAX), 32'(START_MIN), 32'(START_MAX),
          32'(MAXT_MIN), 32'(MAXT_MAX), 32'(HARM_MAX)};
    for (int i = 0; i < 7; i++) begin
      wr(a[i], w[i]);
      rd(a[i]);
      chk(rd_val, e[i]);
    end
    wr(ADDR_IDLE, 32'(IDLE_RST));
    wr(ADDR_START, 32'(START_RST));
    wr(ADDR_MAXT, 32'(MAXT_RST));
    $display("test clamp done");
  endtask

  task automatic t_cold(input logic [1:0] p, input logic [RATIO_W-1:0] r,
                        input logic [RATIO_W-1:0] h, input logic exp_inr,
                        input logic [3:0] rt);
    logic [DATA_W-1:0] sts;
    // status while active, after the first harmonic result
    sts = '0;
    sts[STS_STATE +: 3] = ST_ACTIVE;
    sts[STS_DECIDED] = 1'b1;
    sts[STS_RELEASED] = (r <= h);
    sts[STS_INRUSH] = exp_inr;
    sts[STS_COLD] = 1'b1;
    wr(ADDR_HARM, 32'(h));
    wr(ADDR_ROUTE, 32'(rt));
    wr(ADDR_MASK, 32'hF);
    set_mag(LO, 2'd0, '0);
    cyc(3);
    set_mag(HI, p, r);
    wait_cold(6);
    chkb(cold, 1'b1);
    chkb(inr, 1'b1);
    chk(32'({omc, omi, bmc, bmi}), 32'({rt[0], rt[1], rt[2], rt[3]}));
    chkb(irq, 1'b1);
    cyc(CYC + 3);
    chkb(inr, exp_inr);
    chkb(cold, 1'b1);
    rd(ADDR_STATUS);
    chk(rd_val, sts);
    set_mag(LO, 2'd0, '0);
    cyc(5);
    chkb(cold, 1'b0);
    rd(ADDR_EVENT);
    chk(rd_val, 32'h7);
    cyc(1);
    chkb(irq, 1'b0);
    $display("test cold %0d done", p);
  endtask

  task automatic t_rearm();
    set_mag(LO, 2'd0, '0);
    cyc(3);
    set_mag(HI, 2'd1, '0);
    wait_cold(6);
    chkb(cold, 1'b1);
    set_mag(MID, 2'd1, '0);
    cyc(5);
    chkb(cold, 1'b0);
    set_mag(HI, 2'd1, '0);
    cyc(8);
    chkb(cold, 1'b0);
    set_mag(LO, 2'd0, '0);
    cyc(3);
    set_mag(HI, 2'd1, '0);
    wait_cold(6);
    chkb(cold, 1'b1);
    set_mag(LO, 2'd0, '0);
    cyc(5);
    rd(ADDR_EVENT);
    $display("test rearm done");
  endtask

  task automatic t_window();
    set_mag(LO, 2'd0, '0);
    cyc(3);
    set_mag(MID, 2'd0, '0);
    cyc(WIN + 10);
    set_mag(HI, 2'd1, '0);
    cyc(8);
    chkb(cold, 1'b0);
    rd(ADDR_EVENT);
    chkb(rd_val[EV_REJECT], 1'b1);
    set_mag(LO, 2'd0, '0);
    cyc(3);
    set_mag(MID, 2'd0, '0);
    cyc(WIN - 8);
    set_mag(HI, 2'd2, '0);
    wait_cold(6);
    chkb(cold, 1'b1);
    set_mag(LO, 2'd0, '0);
    cyc(5);
    rd(ADDR_EVENT);
    $display("test window done");
  endtask

  // two steps of five cycles: cold stands ten cycles plus the step tick register
  task automatic t_maxt();
    wr(ADDR_MAXT, 32'h2);
    set_mag(LO, 2'd0, '0);
    cyc(3);
    set_mag(HI, 2'd3, '0);
    wait_cold(6);
    chkb(cold, 1'b1);
    cyc(10);
    chkb(cold, 1'b1);
    cyc(1);
    chkb(cold, 1'b0);
    set_mag(LO, 2'd0, '0);
    cyc(3);
    wr(ADDR_MAXT, 32'(MAXT_RST));
    rd(ADDR_EVENT);
    $display("test maxt done");
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog: the tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = '0;
    wdata = '0;
    mag_req = '0;
    ph_sel = '0;
    ratio_req = '0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    cyc(1);
    t_regs();
    t_clamp();
    t_cold(2'd1, 7'h00, 7'h14, 1'b0, 4'h5);
    t_cold(2'd2, 7'h1E, 7'h14, 1'b1, 4'hA);
    t_cold(2'd3, 7'h00, 7'h00, 1'b1, 4'hF);
    t_rearm();
    t_window();
    t_maxt();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
